// File: reply_formatter.sv
package host_cmd_pkg;
  localparam logic [7:0] FRAME_CHAR = 8'h7e;
  localparam logic [7:0] NET_PREFIX = 8'h2f;
  localparam logic [7:0] USER_MIN = 8'h41;
  localparam logic [7:0] CMD_DIAG = 8'h34;
  localparam logic [7:0] CMD_RESET = 8'h3b;
  localparam logic [7:0] CMD_CLEAR = 8'h3c;
  localparam logic [7:0] CHAR_SPACE = 8'h20;
  localparam logic [7:0] CHAR_HASH = 8'h23;
  localparam logic [7:0] CHAR_ZERO = 8'h30;
  localparam logic [3:0] REPLY_LEN = 4'hb;
  localparam logic [3:0] DIGIT_FIRST = 4'h6;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam int NUM_PORTS = 3;
  localparam logic [1:0] PORT_HOST = 2'h0;
  localparam logic [1:0] PORT_SETUP = 2'h1;
  localparam logic [1:0] PORT_NET = 2'h2;

  typedef logic [1:0] port_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } byte_t;

  typedef struct packed {
    logic [7:0] data;
    port_t port;
  } tagged_byte_t;
endpackage : host_cmd_pkg

module reply_formatter #(
  parameter logic [31:0] MODEL_ID = 32'h4d444c30 // Arbitrary identifier, four ASCII chars
) (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst_n, // Synchronised reset, active low
  input wire logic i_start, // Begin a reply
  input wire logic [15:0] i_count, // Count to report
  input wire host_cmd_pkg::port_t i_port, // Port to answer on
  input wire logic i_ready, // Sink takes byte
  output logic o_busy, // Reply in progress
  output logic o_valid, // Byte on o_rsp is valid
  output host_cmd_pkg::tagged_byte_t o_rsp // Reply byte and port
);
  logic [3:0] idx_q;
  logic [15:0] cnt_q;
  logic busy_q;
  host_cmd_pkg::tagged_byte_t rsp_q;
  logic [3:0] sent_q;

  function automatic logic [7:0] reply_byte(input logic [3:0] idx, input logic [15:0] cnt);
    logic [15:0] div;
    logic [15:0] rem;
    div = 16'h0001;
    rem = 16'h0000;
    if (idx < 4'h4) begin
      reply_byte = MODEL_ID[8'(31 - 8 * idx) -: 8];
    end else if (idx == 4'h4) begin
      reply_byte = host_cmd_pkg::CHAR_SPACE;
    end else if (idx == 4'h5) begin
      reply_byte = host_cmd_pkg::CHAR_HASH;
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (4'(k) < 4'hA - idx) begin
          div = 16'(div * 16'h000a);
        end
      end
      rem = 16'((cnt / div) % 16'h000a);
      reply_byte = host_cmd_pkg::CHAR_ZERO + rem[7:0];
    end
  endfunction : reply_byte

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_q <= 1'b0;
      idx_q <= 4'h0;
      cnt_q <= host_cmd_pkg::COUNT_RST;
      rsp_q <= '0;
    end else if (i_start && !busy_q) begin
      busy_q <= 1'b1;
      idx_q <= 4'h0;
      cnt_q <= i_count;
      rsp_q <= '{data: reply_byte(4'h0, i_count), port: i_port};
    end else if (busy_q && i_ready) begin
      if (idx_q == host_cmd_pkg::REPLY_LEN - 4'h1) begin
        busy_q <= 1'b0;
      end else begin
        idx_q <= idx_q + 4'h1;
        rsp_q.data <= reply_byte(idx_q + 4'h1, cnt_q);
      end
    end
  end

  assign o_busy = busy_q;
  assign o_valid = busy_q;
  assign o_rsp = rsp_q;

  // Bytes handed over so far, kept apart from the index for the length check
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sent_q <= 4'h0;
    end else if (i_start && !busy_q) begin
      sent_q <= 4'h0;
    end else if (busy_q && i_ready) begin
      sent_q <= sent_q + 4'h1;
    end
  end

  reply_length_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (busy_q && i_ready) |=> (busy_q == (sent_q < host_cmd_pkg::REPLY_LEN)))
    else $error("reply length not eleven bytes");
  digit_char_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (busy_q && idx_q >= host_cmd_pkg::DIGIT_FIRST) |->
      (rsp_q.data >= 8'h30 && rsp_q.data <= 8'h39))
    else $error("count digit not a decimal character");
endmodule : reply_formatter

// File: host_command_parser.sv
// Summary of operation
// - Network commands start with slash; unprefixed strings from A upward go to user program.
// - Codes below 65 run here; 65 and above pass to the user program.
// - Host and setup ports are decoded the same way (tilde framing); the network port uses slash prefix and message end.
// - Diagnostic command replies with identifier, space, hash and five-digit count.
// - Count is shown as five decimal digits, leading zeros, up to 65535.
// - Each answered diagnostic request bumps the count by one.
// - Count clears on clear-count, on reset command and at power-up.
// - On the network a bare diagnostic code alone returns the count.
// - Clear-count touches only the count, nothing else.
// - Reset command restarts as a power cycle, stored settings kept.
module host_command_parser (
  input wire logic i_clk_sys, // 25 MHz system clock
  input wire logic i_rstn, // Power-on reset, active low
  input wire logic i_host_valid, // Host serial byte valid
  input wire host_cmd_pkg::byte_t i_host_byte, // Host serial byte
  output logic o_host_ready, // Host byte taken
  input wire logic i_setup_valid, // Setup serial byte valid
  input wire host_cmd_pkg::byte_t i_setup_byte, // Setup serial byte
  output logic o_setup_ready, // Setup byte taken
  input wire logic i_net_valid, // Network byte valid
  input wire host_cmd_pkg::byte_t i_net_byte, // Network byte, last ends message
  output logic o_net_ready, // Network byte taken
  output logic o_sys_valid, // System command pulse
  output host_cmd_pkg::tagged_byte_t o_sys_cmd, // System command code and port
  output logic o_user_valid, // User program data pulse
  output host_cmd_pkg::tagged_byte_t o_user_data, // User program byte and port
  output logic o_restart, // Device restart request pulse
  output logic o_rsp_valid, // Reply byte valid
  output host_cmd_pkg::tagged_byte_t o_rsp, // Reply byte and port
  input wire logic i_rsp_ready, // Reply sink takes byte
  output logic [15:0] o_msg_count // Diagnostic message count
);
  typedef enum logic [2:0] {ST_IDLE, ST_CODE, ST_BODY, ST_DATA, ST_SKIP} st_t;

  logic rst_meta_q;
  logic rst_n_q;
  st_t st_q [host_cmd_pkg::NUM_PORTS];
  logic [7:0] code_q [host_cmd_pkg::NUM_PORTS];
  logic [2:0] vld;
  host_cmd_pkg::byte_t in_b [host_cmd_pkg::NUM_PORTS];
  host_cmd_pkg::port_t sel;
  logic take;
  logic busy;
  logic exec_v;
  logic [7:0] exec_code;
  logic user_v;
  st_t st_d;
  logic [7:0] code_d;
  logic [15:0] count_q;
  logic sys_v_q;
  host_cmd_pkg::tagged_byte_t sys_q;
  logic user_v_q;
  host_cmd_pkg::tagged_byte_t user_q;
  logic restart_q;
  logic diag_start_q;

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  function automatic host_cmd_pkg::port_t pick(input logic [2:0] v);
    if (v[0]) begin
      pick = host_cmd_pkg::PORT_HOST;
    end else if (v[1]) begin
      pick = host_cmd_pkg::PORT_SETUP;
    end else begin
      pick = host_cmd_pkg::PORT_NET;
    end
  endfunction : pick

  function automatic logic is_user(input logic [7:0] c);
    is_user = (c >= host_cmd_pkg::USER_MIN);
  endfunction : is_user

  assign vld = {i_net_valid, i_setup_valid, i_host_valid};
  assign in_b[0] = i_host_byte;
  assign in_b[1] = i_setup_byte;
  assign in_b[2] = i_net_byte;
  assign sel = pick(vld);
  // Stall all inputs while a reply or its start is pending
  assign busy = diag_start_q || o_rsp_valid;
  assign take = vld[sel] && !busy;
  assign o_host_ready = take && (sel == host_cmd_pkg::PORT_HOST);
  assign o_setup_ready = take && (sel == host_cmd_pkg::PORT_SETUP);
  assign o_net_ready = take && (sel == host_cmd_pkg::PORT_NET);

  always_comb begin
    host_cmd_pkg::byte_t b;
    b = in_b[sel];
    st_d = st_q[sel];
    code_d = code_q[sel];
    exec_v = 1'b0;
    exec_code = code_q[sel];
    user_v = 1'b0;
    if (sel != host_cmd_pkg::PORT_NET) begin
      case (st_q[sel])
        ST_IDLE: begin
          if (b.data == host_cmd_pkg::FRAME_CHAR) st_d = ST_CODE;
        end
        ST_CODE: begin
          if (b.data != host_cmd_pkg::FRAME_CHAR) begin
            code_d = b.data;
            user_v = is_user(b.data);
            st_d = ST_BODY;
          end
        end
        default: begin
          if (b.data == host_cmd_pkg::FRAME_CHAR) begin
            exec_v = !is_user(code_q[sel]);
            st_d = ST_IDLE;
          end else begin
            user_v = is_user(code_q[sel]);
          end
        end
      endcase
    end else begin
      case (st_q[sel])
        ST_IDLE: begin
          if (b.data == host_cmd_pkg::NET_PREFIX) begin
            st_d = b.last ? ST_IDLE : ST_CODE;
          end else if (is_user(b.data)) begin
            user_v = 1'b1;
            st_d = b.last ? ST_IDLE : ST_DATA;
          end else if (b.last) begin
            exec_v = 1'b1;
            exec_code = b.data;
          end else begin
            st_d = ST_SKIP;
          end
        end
        ST_CODE: begin
          code_d = b.data;
          if (is_user(b.data)) begin
            user_v = 1'b1;
            st_d = b.last ? ST_IDLE : ST_DATA;
          end else if (b.last) begin
            exec_v = 1'b1;
            exec_code = b.data;
            st_d = ST_IDLE;
          end else begin
            st_d = ST_BODY;
          end
        end
        ST_BODY: begin
          if (b.last) begin
            exec_v = 1'b1;
            st_d = ST_IDLE;
          end
        end
        ST_DATA: begin
          user_v = 1'b1;
          if (b.last) st_d = ST_IDLE;
        end
        default: begin
          if (b.last) st_d = ST_IDLE;
        end
      endcase
    end
    if (!take) begin
      exec_v = 1'b0;
      user_v = 1'b0;
    end
  end

  // Parser state per port; one decoder shared by all ports
  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < host_cmd_pkg::NUM_PORTS; i++) begin
        st_q[i] <= ST_IDLE;
        code_q[i] <= 8'h00;
      end
    end else if (restart_q) begin
      for (int i = 0; i < host_cmd_pkg::NUM_PORTS; i++) begin
        st_q[i] <= ST_IDLE;
      end
    end else if (take) begin
      st_q[sel] <= st_d;
      code_q[sel] <= code_d;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sys_v_q <= 1'b0;
      sys_q <= '0;
      user_v_q <= 1'b0;
      user_q <= '0;
      restart_q <= 1'b0;
      diag_start_q <= 1'b0;
    end else begin
      sys_v_q <= exec_v;
      sys_q <= '{data: exec_code, port: sel};
      user_v_q <= user_v;
      user_q <= '{data: in_b[sel].data, port: sel};
      restart_q <= exec_v && (exec_code == host_cmd_pkg::CMD_RESET);
      diag_start_q <= exec_v && (exec_code == host_cmd_pkg::CMD_DIAG);
    end
  end

  // Count reported, then advanced, as the reply starts
  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      count_q <= host_cmd_pkg::COUNT_RST;
    end else if (exec_v && (exec_code == host_cmd_pkg::CMD_CLEAR ||
                 exec_code == host_cmd_pkg::CMD_RESET)) begin
      count_q <= host_cmd_pkg::COUNT_RST;
    end else if (diag_start_q) begin
      count_q <= count_q + 16'h0001;
    end
  end

  reply_formatter u_reply (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(rst_n_q),
    .i_start(diag_start_q),
    .i_count(count_q),
    .i_port(sys_q.port),
    .i_ready(i_rsp_ready),
    .o_busy(),
    .o_valid(o_rsp_valid),
    .o_rsp(o_rsp)
  );

  assign o_sys_valid = sys_v_q;
  assign o_sys_cmd = sys_q;
  assign o_user_valid = user_v_q;
  assign o_user_data = user_q;
  assign o_restart = restart_q;
  assign o_msg_count = count_q;

  count_step_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_q)
    diag_start_q |=> count_q == 16'($past(count_q) + 16'h0001))
    else $error("count did not advance on diagnostic request");
  count_clear_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_q)
    (exec_v && exec_code == host_cmd_pkg::CMD_CLEAR) |=> count_q == 16'h0000)
    else $error("count not cleared");
  clear_norestart_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_q)
    (exec_v && exec_code == host_cmd_pkg::CMD_CLEAR) |=> !restart_q)
    else $error("clear-count restarted device");
  restart_pulse_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_q)
    (exec_v && exec_code == host_cmd_pkg::CMD_RESET) |=> restart_q ##1 !restart_q)
    else $error("restart not a single pulse");
  count_wrap_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_q)
    (diag_start_q && count_q == 16'hffff) |=> count_q == 16'h0000)
    else $error("count did not wrap");
  split_class_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_q)
    sys_v_q |-> sys_q.data < host_cmd_pkg::USER_MIN)
    else $error("user code executed as system command");
  diag_reply_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_q)
    diag_start_q |=> o_rsp_valid && o_rsp.data == 8'h4d)
    else $error("reply did not start with identifier");
  frame_exec_a: assert property (@(posedge i_clk_sys) disable iff (!rst_n_q)
    (exec_v && sel != host_cmd_pkg::PORT_NET) |-> in_b[sel].data == host_cmd_pkg::FRAME_CHAR)
    else $error("serial command executed without closing frame");
endmodule : host_command_parser

// File: host_sender.sv
module host_sender (
  input wire logic i_clk_sys, // System clock
  input wire logic i_ready, // Byte taken
  output logic o_valid, // Byte offered
  output host_cmd_pkg::byte_t o_byte // Byte and message end
);
  timeunit 1ns;
  timeprecision 1ps;
  host_cmd_pkg::byte_t q[$];
  initial begin
    o_valid = 1'b0;
    o_byte = '0;
  end
  function automatic void push(input logic [7:0] d, input logic l);
    q.push_back({d, l});
  endfunction : push
  function automatic bit idle();
    return q.size() == 0 && !o_valid;
  endfunction : idle
  // Offer held until taken, then the line shows the inverse
  always @(posedge i_clk_sys) begin
    if (o_valid && i_ready) begin
      void'(q.pop_front());
      o_valid <= 1'b0;
      o_byte <= ~o_byte;
    end else if (!o_valid && q.size() > 0 && $urandom_range(3) != 0) begin
      o_valid <= 1'b1;
      o_byte <= q[0];
    end
  end
endmodule : host_sender

// File: test_host_command_parser.sv
module test_host_command_parser;
  timeunit 1ns;
  timeprecision 1ps;
  typedef host_cmd_pkg::tagged_byte_t tb_t;
  logic clk, rstn, rsp_ready, sys_valid, user_valid, restart, rsp_valid;
  logic [2:0] v, r;
  host_cmd_pkg::byte_t b [3];
  tb_t sys_cmd, user_data, rsp;
  logic [15:0] msg_count;
  tb_t sys_q[$], user_q[$], rsp_q[$], sys_e[$], user_e[$], rsp_e[$];
  int fail_count, checked, count_m, restarts;
  host_sender host_tx (.i_clk_sys(clk), .i_ready(r[0]), .o_valid(v[0]), .o_byte(b[0]));
  host_sender setup_tx (.i_clk_sys(clk), .i_ready(r[1]), .o_valid(v[1]), .o_byte(b[1]));
  host_sender net_tx (.i_clk_sys(clk), .i_ready(r[2]), .o_valid(v[2]), .o_byte(b[2]));
  host_command_parser uut (.i_clk_sys(clk), .i_rstn(rstn), .i_host_valid(v[0]),
    .i_host_byte(b[0]), .o_host_ready(r[0]), .i_setup_valid(v[1]), .i_setup_byte(b[1]),
    .o_setup_ready(r[1]), .i_net_valid(v[2]), .i_net_byte(b[2]), .o_net_ready(r[2]),
    .o_sys_valid(sys_valid), .o_sys_cmd(sys_cmd), .o_user_valid(user_valid),
    .o_user_data(user_data), .o_restart(restart), .o_rsp_valid(rsp_valid), .o_rsp(rsp),
    .i_rsp_ready(rsp_ready), .o_msg_count(msg_count));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (sys_valid === 1'b1) sys_q.push_back(sys_cmd);
    if (user_valid === 1'b1) user_q.push_back(user_data);
    if (restart === 1'b1) restarts++;
    if (rsp_valid === 1'b1 && rsp_ready) rsp_q.push_back(rsp);
    rsp_ready <= 1'($urandom_range(1));
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic send(input int p, input string s, input bit pre);
    string f;
    f = (p == 2) ? (pre ? {"/", s} : s) : {"~", s, "~"};
    for (int i = 0; i < f.len(); i++) begin
      if (p == 0) host_tx.push(f[i], 1'b0);
      else if (p == 1) setup_tx.push(f[i], 1'b0);
      else net_tx.push(f[i], i == f.len() - 1);
    end
  endtask : send
  task automatic exp_sys(input logic [7:0] c, input int p);
    sys_e.push_back({c, host_cmd_pkg::port_t'(p)});
  endtask : exp_sys
  task automatic exp_user(input string s, input int p);
    for (int i = 0; i < s.len(); i++) user_e.push_back({s[i], host_cmd_pkg::port_t'(p)});
  endtask : exp_user
  task automatic exp_diag(input int p);
    string t;
    exp_sys(8'h34, p);
    t = $sformatf("MDL0 #%05d", count_m);
    for (int i = 0; i < t.len(); i++) rsp_e.push_back({t[i], host_cmd_pkg::port_t'(p)});
    count_m = (count_m + 1) % 65536;
  endtask : exp_diag
  // Order kept per port only: ports interleave with the random offer timing
  task automatic cmpq(input string n, input tb_t a[$], input tb_t e[$]);
    tb_t ap[$];
    tb_t ep[$];
    for (int p = 0; p < 3; p++) begin
      ap = a.find(x) with (x.port == host_cmd_pkg::port_t'(p));
      ep = e.find(x) with (x.port == host_cmd_pkg::port_t'(p));
      check({n, " length"}, 16'(ap.size()), 16'(ep.size()));
      foreach (ep[i]) if (i < ap.size()) check(n, {6'h0, ap[i]}, {6'h0, ep[i]});
    end
  endtask : cmpq
  task automatic drain();
    int n;
    n = 0;
    while (n < 4) begin
      @(posedge clk);
      n = (host_tx.idle() && setup_tx.idle() && net_tx.idle() && !rsp_valid) ? n + 1 : 0;
    end
  endtask : drain
  task automatic end_test(input string name);
    drain();
    cmpq("system command", sys_q, sys_e);
    cmpq("user data", user_q, user_e);
    cmpq("reply", rsp_q, rsp_e);
    check("message count", msg_count, 16'(count_m));
    sys_q = {};
    user_q = {};
    rsp_q = {};
    sys_e = {};
    user_e = {};
    rsp_e = {};
    $display("test done: %s", name);
  endtask : end_test
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    complete_run();
  end
  initial begin
    string s;
    rstn = 1'b0;
    rsp_ready = 1'b0;
    fail_count = 0;
    checked = 0;
    count_m = 0;
    restarts = 0;
    void'($urandom(32'h7ad4));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    check("count at power-up", msg_count, 16'h0000);
    // One diagnostic at a time, as each reply carries the running count
    for (int p = 0; p < 3; p++) begin
      send(p, "4", 1'b1);
      exp_diag(p);
      drain();
    end
    send(2, "4", 1'b0);
    exp_diag(2);
    end_test("diagnostic on every port");
    s = "A...";
    for (int i = 1; i < 4; i++) s[i] = 8'h21 + 8'($urandom_range(92));
    send(0, "@", 1'b1);
    exp_sys(8'h40, 0);
    send(0, s, 1'b1);
    exp_user(s, 0);
    send(1, "AZ", 1'b1);
    exp_user("AZ", 1);
    send(2, "Bq", 1'b1);
    exp_user("Bq", 2);
    send(2, "Cx", 1'b0);
    exp_user("Cx", 2);
    end_test("system and user split");
    send(0, "<", 1'b1);
    exp_sys(8'h3c, 0);
    count_m = 0;
    drain();
    send(1, "4", 1'b1);
    exp_diag(1);
    end_test("clear count");
    send(0, "4", 1'b1);
    exp_diag(0);
    send(0, ";", 1'b1);
    exp_sys(8'h3b, 0);
    count_m = 0;
    end_test("reset command");
    check("message count", msg_count, 16'h0000);
    check("restart pulses", 16'(restarts), 16'h0001);
    send(0, "~4", 1'b1);
    exp_diag(0);
    end_test("reopened frame");
    complete_run();
  end
endmodule : test_host_command_parser
